// File: cdp_pkg.sv
// Package: register map, field layout, reset values and carrier types of the clock divider block
package cdp_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CLOCK_DIVISOR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PLL_FEEDBACK_DIVISOR = 4'h4;

  // ----------------------------------------
  // Clock divisor control fields
  // ----------------------------------------
  localparam int RECOVER_BIT = 15;
  localparam int RATIO_MSB = 14;
  localparam int RATIO_LSB = 12;
  localparam int ENABLE_BIT = 11;
  localparam int POSTSCALER_MSB = 10;
  localparam int POSTSCALER_LSB = 8;
  localparam int VCO_DIV_MSB = 7;
  localparam int VCO_DIV_LSB = 6;
  localparam int PRE_DIV_MSB = 4;
  localparam int PRE_DIV_LSB = 0;

  // ----------------------------------------
  // Feedback divisor field
  // ----------------------------------------
  localparam int FEEDBACK_MSB = 8;
  localparam logic [8:0] FEEDBACK_OFFSET = 9'h002;

  // ----------------------------------------
  // Reset values and special field codes
  // ----------------------------------------
  localparam logic [2:0] RESET_RATIO = 3'h0;
  localparam logic [2:0] RESET_POSTSCALER = 3'h1;
  localparam logic [1:0] RESET_VCO_DIV = 2'h0;
  localparam logic [4:0] RESET_PRE_DIV = 5'h00;
  localparam logic [8:0] RESET_FEEDBACK = 9'h030;
  localparam logic [1:0] VCO_DIV_RESERVED = 2'h2;
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] POSTSCALER_TOP = 3'h7;
  localparam logic [8:0] FRC_DIVIDE_TOP = 9'h100;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic recover_on_interrupt;
    logic [2:0] proc_clock_reduction_ratio;
    logic reduction_enable;
    logic [2:0] fast_rc_postscaler;
    logic [1:0] vco_output_divider;
    logic [4:0] pll_input_divider;
  } cdp_divisor_type;

  typedef struct packed {
    logic [8:0] post_divide_factor;
    logic [4:0] pll_input_divider;
    logic [9:0] multiplier;
    logic [8:0] fast_rc_divide;
    logic [7:0] proc_divide;
  } cdp_clock_setup_type;

endpackage

// File: cdp_clock_divider.sv
// Clock divider and PLL setting registers with classic Wishbone slave
// Behaviour
// RQ1: With recover-on-interrupt set, any interrupt clears the reduction enable bit, else it is kept.
// RQ2: Writes to the reduction ratio field are ignored while reduction is enabled.
// RQ3: The reduction enable bit cannot be set while the reduction ratio field is 000.
// RQ4: The fast RC postscaler at bits 10-8 divides by two to the code, by 256 at 111, reset code 001.
// RQ5: The clock divisor register returns to defaults only on power-on reset.
// RQ6: The VCO output divider at bits 7-6 selects the PLL postscale and code 10 is reserved.
// RQ7: The feedback divisor at bits 8-0 sets the multiplier as code plus two, default 50.
// RQ8: The feedback divisor register is reset only by power-on reset.
// RQ9: The processor clock divide is two to the ratio while enabled and one while disabled.
// RQ10: The input divider sits in bits 4-0, bit 5 and feedback bits 15-9 read as zero.
module cdp_clock_divider (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic POR_B,
  input wire logic INTERRUPT,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  output cdp_pkg::cdp_clock_setup_type SETUP
);

  // ----------------------------------------
  // Reset synchronisers
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;
  logic por_meta;
  logic por_sync;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  always_ff @(posedge CLOCK or negedge POR_B) begin
    if (!POR_B) begin
      por_meta <= 1'b0;
      por_sync <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_sync <= por_meta;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic req;
  logic hit_div;
  logic hit_fbd;
  logic wr_div;
  logic wr_fbd;

  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign hit_div = WB_ADR_I == cdp_pkg::ADDR_CLOCK_DIVISOR_CONTROL;
  assign hit_fbd = WB_ADR_I == cdp_pkg::ADDR_PLL_FEEDBACK_DIVISOR;
  assign wr_div = req && WB_WE_I && hit_div;
  assign wr_fbd = req && WB_WE_I && hit_fbd;

  always_ff @(posedge CLOCK or negedge rst_sync) begin
    if (!rst_sync) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && (hit_div || hit_fbd);
      WB_ERR_O <= req && !(hit_div || hit_fbd);
    end
  end

  // ----------------------------------------
  // Clock divisor control register
  // ----------------------------------------
  cdp_pkg::cdp_divisor_type div;
  logic [2:0] new_ratio;
  logic low_lane;
  logic high_lane;

  assign low_lane = WB_SEL_I[0];
  assign high_lane = WB_SEL_I[1];
  // Ratio held while enabled
  assign new_ratio = (high_lane && !div.reduction_enable) ?
    WB_DAT_I[cdp_pkg::RATIO_MSB:cdp_pkg::RATIO_LSB] : div.proc_clock_reduction_ratio; // [RQ2]

  always_ff @(posedge CLOCK or negedge por_sync) begin
    if (!por_sync) begin // [RQ5]
      div.recover_on_interrupt <= 1'b0;
      div.fast_rc_postscaler <= cdp_pkg::RESET_POSTSCALER; // [RQ4]
      div.vco_output_divider <= cdp_pkg::RESET_VCO_DIV;
      div.pll_input_divider <= cdp_pkg::RESET_PRE_DIV;
      div.proc_clock_reduction_ratio <= cdp_pkg::RESET_RATIO;
      div.reduction_enable <= 1'b0;
    end else begin
      if (wr_div) begin
        if (high_lane) begin
          div.recover_on_interrupt <= WB_DAT_I[cdp_pkg::RECOVER_BIT];
          div.fast_rc_postscaler <= WB_DAT_I[cdp_pkg::POSTSCALER_MSB:cdp_pkg::POSTSCALER_LSB];
        end
        if (low_lane) begin
          div.vco_output_divider <= WB_DAT_I[cdp_pkg::VCO_DIV_MSB:cdp_pkg::VCO_DIV_LSB]; // [RQ6]
          div.pll_input_divider <= WB_DAT_I[cdp_pkg::PRE_DIV_MSB:cdp_pkg::PRE_DIV_LSB]; // [RQ10]
        end
        div.proc_clock_reduction_ratio <= new_ratio; // [RQ2]
      end
      // Enable: interrupt clear beats a software set
      if (INTERRUPT && div.recover_on_interrupt) begin
        div.reduction_enable <= 1'b0; // [RQ1]
      end else if (wr_div && high_lane) begin
        div.reduction_enable <= WB_DAT_I[cdp_pkg::ENABLE_BIT] &&
          (new_ratio != cdp_pkg::RATIO_NONE); // [RQ3]
      end
    end
  end

  // ----------------------------------------
  // PLL feedback divisor register
  // ----------------------------------------
  logic [8:0] fbd;

  always_ff @(posedge CLOCK or negedge por_sync) begin
    if (!por_sync) begin
      fbd <= cdp_pkg::RESET_FEEDBACK; // [RQ8]
    end else if (wr_fbd) begin
      if (high_lane) begin
        fbd[8] <= WB_DAT_I[8];
      end
      if (low_lane) begin
        fbd[7:0] <= WB_DAT_I[7:0];
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic read_div;

  always_ff @(posedge CLOCK or negedge rst_sync) begin
    if (!rst_sync) begin
      read_div <= 1'b0;
    end else begin
      read_div <= req && !WB_WE_I && hit_div;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync) begin
    if (!rst_sync) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (req && !WB_WE_I && hit_div) begin
      WB_DAT_O <= {16'h0000, div[14:5], 1'b0, div[4:0]}; // [RQ10]
    end else if (req && !WB_WE_I && hit_fbd) begin
      WB_DAT_O <= {23'h000000, fbd}; // [RQ10]
    end else begin
      WB_DAT_O <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Clock setup outputs
  // ----------------------------------------
  logic setup_live;

  always_ff @(posedge CLOCK or negedge rst_sync) begin
    if (!rst_sync) begin
      setup_live <= 1'b0;
    end else begin
      setup_live <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync) begin
    if (!rst_sync) begin
      SETUP <= '0;
    end else begin
      SETUP.post_divide_factor <= 9'h002 << div.vco_output_divider; // [RQ6]
      SETUP.pll_input_divider <= div.pll_input_divider; // [RQ10]
      SETUP.multiplier <= {1'b0, fbd} + {1'b0, cdp_pkg::FEEDBACK_OFFSET}; // [RQ7]
      SETUP.fast_rc_divide <= (div.fast_rc_postscaler == cdp_pkg::POSTSCALER_TOP) ?
        cdp_pkg::FRC_DIVIDE_TOP : (9'h001 << div.fast_rc_postscaler); // [RQ4]
      SETUP.proc_divide <= div.reduction_enable ?
        (8'h01 << div.proc_clock_reduction_ratio) : 8'h01; // [RQ9]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_irq_recover;
    INTERRUPT && div.recover_on_interrupt;
  endsequence

  property p_irq_clear;
    @(posedge CLOCK) disable iff (!por_sync)
      s_irq_recover |=> !div.reduction_enable;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("enable kept after interrupt"); // [RQ1]

  property p_ratio_hold;
    @(posedge CLOCK) disable iff (!por_sync)
      div.reduction_enable |=> $stable(div.proc_clock_reduction_ratio);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio changed while enabled"); // [RQ2]

  property p_no_zero_enable;
    @(posedge CLOCK) disable iff (!por_sync)
      div.reduction_enable |-> div.proc_clock_reduction_ratio != cdp_pkg::RATIO_NONE;
  endproperty
  a_no_zero_enable: assert property (p_no_zero_enable) else $error("enabled with ratio 0"); // [RQ3]

  property p_frc;
    @(posedge CLOCK) disable iff (!rst_sync)
      setup_live |-> SETUP.fast_rc_divide == (($past(div.fast_rc_postscaler) == 3'h7) ?
        9'h100 : (9'h001 << $past(div.fast_rc_postscaler)));
  endproperty
  a_frc: assert property (p_frc) else $error("postscaler divide wrong"); // [RQ4]

  property p_mult;
    @(posedge CLOCK) disable iff (!rst_sync)
      setup_live |-> SETUP.multiplier == {1'b0, $past(fbd)} + 10'h002;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong"); // [RQ7]

  property p_proc;
    @(posedge CLOCK) disable iff (!rst_sync)
      setup_live |-> SETUP.proc_divide == ($past(div.reduction_enable) ?
        (8'h01 << $past(div.proc_clock_reduction_ratio)) : 8'h01);
  endproperty
  a_proc: assert property (p_proc) else $error("processor divide wrong"); // [RQ9]

  property p_fbd_keep;
    @(posedge CLOCK) disable iff (!por_sync)
      !wr_fbd |=> $stable(fbd);
  endproperty
  a_fbd_keep: assert property (p_fbd_keep) else $error("feedback changed without write"); // [RQ8]

  property p_div_keep;
    @(posedge CLOCK) disable iff (!por_sync)
      !wr_div |=> $stable(div.fast_rc_postscaler) && $stable(div.pll_input_divider);
  endproperty
  a_div_keep: assert property (p_div_keep) else $error("divisor changed without write"); // [RQ5]

  property p_read_zero;
    @(posedge CLOCK) disable iff (!rst_sync)
      WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000 &&
        (read_div ? WB_DAT_O[5] == 1'b0 : WB_DAT_O[15:9] == 7'h00);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unimplemented bits nonzero"); // [RQ10]

endmodule

// File: tb_clock_divider_and_pll_setting.sv
// Self-checking testbench of the clock divider and PLL setting registers
module tb_clock_divider_and_pll_setting;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic interrupt = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic err;
  cdp_pkg::cdp_clock_setup_type setup;
  logic [31:0] rd;
  logic [31:0] r;
  logic got_err;
  logic [15:0] div;
  logic [8:0] fb;
  int n_fail = 0;
  int checks = 0;
  int seed;
  always #5 clock = ~clock;
  cdp_clock_divider dut_u (.CLOCK(clock), .RST_B(rst_b), .POR_B(por_b), .INTERRUPT(interrupt),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err), .SETUP(setup));
  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [15:0] upd(input logic [15:0] c, input logic [15:0] w,
      input logic [3:0] s);
    logic [2:0] q;
    logic e;
    q = (s[1] && !c[11]) ? w[14:12] : c[14:12];
    e = s[1] ? (w[11] & (q != 3'h0)) : c[11];
    return {s[1] ? w[15] : c[15], q, e, s[1] ? w[10:8] : c[10:8],
      s[0] ? {w[7:6], 1'b0, w[4:0]} : c[7:0]};
  endfunction
  function automatic cdp_pkg::cdp_clock_setup_type exp_setup(input logic [15:0] d,
      input logic [8:0] f);
    cdp_pkg::cdp_clock_setup_type s;
    s.post_divide_factor = 9'h002 << d[7:6];
    s.pll_input_divider = d[4:0];
    s.multiplier = {1'b0, f} + 10'h002;
    s.fast_rc_divide = (d[10:8] == 3'h7) ? 9'h100 : (9'h001 << d[10:8]);
    s.proc_divide = d[11] ? 8'h01 << d[14:12] : 8'h01;
    return s;
  endfunction
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= lanes;
    dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    rd = dat_o;
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      n_fail++;
      results();
    end
  endtask
  task wr_div(input logic [15:0] d);
    bus(1'b1, cdp_pkg::ADDR_CLOCK_DIVISOR_CONTROL, {16'h0, d});
    div = upd(div, d, lanes);
  endtask
  task wr_fb(input logic [31:0] d);
    bus(1'b1, cdp_pkg::ADDR_PLL_FEEDBACK_DIVISOR, d);
    fb = {lanes[1] ? d[8] : fb[8], lanes[0] ? d[7:0] : fb[7:0]};
  endtask
  task rd_chk;
    bus(1'b0, cdp_pkg::ADDR_CLOCK_DIVISOR_CONTROL, 32'h0);
    chk(48'(rd), 48'({16'h0, div}));
    bus(1'b0, cdp_pkg::ADDR_PLL_FEEDBACK_DIVISOR, 32'h0);
    chk(48'(rd), 48'({23'h0, fb}));
    @(negedge clock);
    chk(48'(setup), 48'(exp_setup(div, fb)));
  endtask
  task reset_pulse(input logic por);
    @(posedge clock);
    rst_b <= 1'b0;
    if (por) por_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task pulse_irq;
    @(posedge clock);
    interrupt <= 1'b1;
    @(posedge clock);
    interrupt <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hC5C9;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (3) @(posedge clock);
    div = 16'h0100;
    fb = 9'h030;
    rd_chk();
    for (int k = 0; k < 8; k++) begin
      wr_div({1'b0, 3'(k), 1'b1, 3'(k), k[1], k[1] | k[0], 1'b0, 5'(k)});
      rd_chk();
    end
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      lanes = k[0] ? 4'hF : r[3:0];
      r = $random(seed);
      if (r[7:6] == 2'h2) r[7] = 1'b0;
      wr_div(r[15:0]);
      wr_fb({16'h0, r[31:16]});
      rd_chk();
    end
    lanes = 4'hF;
    wr_fb(32'hFFFFFFFF);
    wr_div(16'h0000);
    wr_div(16'h0800);
    rd_chk();
    wr_div(16'hB800);
    pulse_irq();
    div[11] = 1'b0;
    rd_chk();
    wr_div(16'h3800);
    pulse_irq();
    rd_chk();
    reset_pulse(1'b0);
    rd_chk();
    reset_pulse(1'b1);
    div = 16'h0100;
    fb = 9'h030;
    rd_chk();
    bus(1'b1, 4'h8, 32'h0000FFFF);
    chk(48'(got_err), 48'h1);
    rd_chk();
    results();
  end
endmodule
